// ---- hdl/asq_scan_readout.sv ----
// conversion sequencer, result memory and two-byte readout for a serial ADC
// What this block does
// - results read back first in, first out
// - reference pin skipped in multichannel scans
// - read pointer wraps to first result
// - internal mode reads only current results
// - clock select one uses bus clock
// - external: track on ninth edge, convert two later
// - external: four high bits, convert until nack
// - mode 00 scans up from channel 0
// - mode 01 converts selected channel eight times
// - mode 10 scans up from fixed start
// - mode 11 converts selected channel once
// - external: modes 01 and 11 repeat until nack
// - result sent as two bytes, four leading highs
// - missing acknowledge ends memory transmission
// - no memory read without a conversion
// - power-on config: single conversion channel 0
// - analog shut down between conversions when idle
// - external: idle only after stop, nack, restart
// - internal: power down once results stored
// - internal: results kept until stop or restart
// - internal: hold bus clock low while converting
// - clock select resets to internal mode
// - release data line on not-acknowledge
`timescale 1ns/1ns
module asq_scan_readout
	import asq_pkg::*;
(
	// system
	input  wire logic                 clk,
	input  wire logic                 reset,
	// AXI4-Lite slave
	input  wire logic [7:0]           s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [7:0]           s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	// serial link, after address decode by the link front end
	input  wire logic                 sclIn,
	input  wire logic                 sdaIn,
	input  wire logic                 addrMatch,
	input  wire logic                 busStop,
	input  wire logic                 busRestart,
	output logic                      sclOe_n,
	output logic                      sdaOe_n,
	// analog core
	output logic [3:0]                adcChannel,
	output logic                      adcTrack,
	output logic                      adcStart,
	output logic                      analogOn,
	input  wire logic [RES_BITS-1:0]  adcResult
);
	import asq_pkg::*;

	// synchronisers for pins from outside the clock domain
	logic [1:0] sclSync_ff, sdaSync_ff, matchSync_ff, stopSync_ff, rstrtSync_ff;
	logic       sclPrev_ff;
	always_ff @(posedge clk) begin
		if (reset) begin
			sclSync_ff   <= 2'h3;
			sdaSync_ff   <= 2'h3;
			matchSync_ff <= 2'h0;
			stopSync_ff  <= 2'h0;
			rstrtSync_ff <= 2'h0;
			sclPrev_ff   <= 1'b1;
		end else begin
			sclSync_ff   <= {sclSync_ff[0], sclIn};
			sdaSync_ff   <= {sdaSync_ff[0], sdaIn};
			matchSync_ff <= {matchSync_ff[0], addrMatch};
			stopSync_ff  <= {stopSync_ff[0], busStop};
			rstrtSync_ff <= {rstrtSync_ff[0], busRestart};
			sclPrev_ff   <= sclSync_ff[1];
		end
	end
	logic sclRise, sclFall, sda, matched, endTxn;
	assign sclRise = sclSync_ff[1] & ~sclPrev_ff;
	assign sclFall = ~sclSync_ff[1] & sclPrev_ff;
	assign sda     = sdaSync_ff[1];
	assign matched = matchSync_ff[1];
	assign endTxn  = stopSync_ff[1] | rstrtSync_ff[1];

	// configuration register
	logic [7:0] cfg_ff;
	logic       extClk, refPin;
	logic [1:0] scanMode;
	logic [3:0] chSel;
	assign extClk   = cfg_ff[CFG_CLK_POS];
	assign refPin   = cfg_ff[CFG_REF_PIN_FUNCTION_BIT_POS];
	assign scanMode = cfg_ff[CFG_SCAN_LSB +: 2];
	assign chSel    = cfg_ff[CFG_CS_LSB +: 4];

	// scan limits
	logic [3:0] topCh, firstCh, lastCh;
	always_comb begin
		topCh = (chSel > CH_MAX) ? CH_MAX : chSel;
		if (refPin && topCh > CH_MAX_REF)
			topCh = CH_MAX_REF;
		case (scanMode)
			SCAN_UP: begin
				firstCh = 4'h0;
				lastCh  = topCh;
			end
			SCAN_UPPER: begin
				firstCh = (NUM_CH == 4) ? UPPER_START_SMALL : UPPER_START;
				lastCh  = (topCh < firstCh) ? firstCh : topCh;
			end
			default: begin
				firstCh = topCh;
				lastCh  = topCh;
			end
		endcase
	end

	// result memory
	logic [RES_BITS-1:0] mem_ff [MEM_DEPTH];
	logic [3:0]          wrPtr_ff, rdPtr_ff, count_ff, curCh_ff, done_ff;
	logic                memWr;
	genvar gi;
	generate
		for (gi = 0; gi < MEM_DEPTH; gi++) begin : g_mem
			always_ff @(posedge clk) begin
				if (memWr && wrPtr_ff == 4'(gi))
					mem_ff[gi] <= adcResult;
			end
		end
	endgenerate

	// sequencer and readout
	asq_state_t state_ff;
	logic [3:0]  bitCnt_ff;
	logic [2:0]  edgeCnt_ff;
	logic [15:0] shift_ff;
	logic        byteSel_ff;
	logic [15:0] convCnt_ff;
	logic        sclHold_ff, sdaDrive_ff, track_ff, start_ff, anaOn_ff;
	logic [15:0] word;
	logic [15:0] extWord;
	logic        seqEnd;
	assign word    = {4'hF, mem_ff[rdPtr_ff]};
	assign extWord = (bitCnt_ff == 4'(LEAD_HIGH) && !byteSel_ff) ? {adcResult, 4'hF}
	                                                              : shift_ff;
	assign seqEnd  = (scanMode == SCAN_REPEAT) ? (done_ff == REPEAT_CNT - 4'h1)
	                                          : (curCh_ff == lastCh);
	assign memWr   = (state_ff == ST_CONV) && !extClk && convCnt_ff == 16'(CONV_CYC - 1);

	always_ff @(posedge clk) begin
		if (reset) begin
			state_ff    <= ST_IDLE;
			wrPtr_ff    <= 4'h0;
			rdPtr_ff    <= 4'h0;
			count_ff    <= 4'h0;
			curCh_ff    <= 4'h0;
			done_ff     <= 4'h0;
			bitCnt_ff   <= 4'h0;
			edgeCnt_ff  <= 3'h0;
			shift_ff    <= 16'hFFFF;
			byteSel_ff  <= 1'b0;
			convCnt_ff  <= 16'h0;
			sclHold_ff  <= 1'b0;
			sdaDrive_ff <= 1'b0;
			track_ff    <= 1'b0;
			start_ff    <= 1'b0;
			anaOn_ff    <= 1'b0;
		end else begin
			start_ff <= 1'b0;
			case (state_ff)
				ST_IDLE: begin
					anaOn_ff    <= 1'b0;
					sdaDrive_ff <= 1'b0;
					if (matched) begin
						state_ff   <= ST_ADDR;
						edgeCnt_ff <= 3'h0;
					end
				end
				ST_ADDR: begin
					if (endTxn)
						state_ff <= ST_IDLE;
					else if (extClk && sclRise) begin
						// ninth rising edge of the address byte starts tracking
						state_ff   <= ST_TRACK;
						anaOn_ff   <= 1'b1;
						track_ff   <= 1'b1;
						curCh_ff   <= firstCh;
						done_ff    <= 4'h0;
						edgeCnt_ff <= 3'h0;
						shift_ff   <= 16'hFFFF;
						bitCnt_ff  <= 4'h0;
						byteSel_ff <= 1'b0;
					end else if (!extClk && sclFall) begin
						state_ff   <= ST_CONV;
						sclHold_ff <= 1'b1;
						anaOn_ff   <= 1'b1;
						start_ff   <= 1'b1;
						curCh_ff   <= firstCh;
						done_ff    <= 4'h0;
						wrPtr_ff   <= 4'h0;
						count_ff   <= 4'h0;
						convCnt_ff <= 16'h0;
					end
				end
				ST_TRACK: begin
					// external mode: leading highs stream while this sample converts, then its result bits
					if (endTxn)
						state_ff <= ST_IDLE;
					else if (sclFall) begin
						sdaDrive_ff <= (bitCnt_ff == 4'h8) ? 1'b0 : ~extWord[15];
						shift_ff    <= {extWord[14:0], 1'b1};
						bitCnt_ff   <= bitCnt_ff + 4'h1;
						if (bitCnt_ff == 4'h8)
							state_ff <= ST_ACK;
					end
					if (sclRise && edgeCnt_ff != 3'(TRACK_EDGES)) begin
						edgeCnt_ff <= edgeCnt_ff + 3'h1;
						if (edgeCnt_ff == 3'(TRACK_EDGES - 1)) begin
							track_ff <= 1'b0;
							start_ff <= 1'b1;
						end
					end
				end
				ST_CONV: begin
					convCnt_ff <= convCnt_ff + 16'h1;
					if (memWr) begin
						wrPtr_ff   <= wrPtr_ff + 4'h1;
						count_ff   <= count_ff + 4'h1;
						done_ff    <= done_ff + 4'h1;
						convCnt_ff <= 16'h0;
						if (seqEnd) begin
							state_ff   <= ST_SEND;
							sclHold_ff <= 1'b0;
							anaOn_ff   <= 1'b0;
							rdPtr_ff   <= 4'h0;
							byteSel_ff <= 1'b0;
							bitCnt_ff  <= 4'h1;
						end else begin
							start_ff <= 1'b1;
							if (scanMode != SCAN_REPEAT)
								curCh_ff <= curCh_ff + 4'h1; // limit via lastCh
						end
					end
				end
				ST_SEND: begin
					if (endTxn)
						state_ff <= ST_IDLE;
					else if (sclFall) begin
						sdaDrive_ff <= (bitCnt_ff == 4'h8) ? 1'b0 : ~word[4'hF - {byteSel_ff, bitCnt_ff[2:0]}];
						bitCnt_ff   <= bitCnt_ff + 4'h1;
						if (bitCnt_ff == 4'h8)
							state_ff <= ST_ACK;
					end
				end
				ST_ACK: begin
					if (endTxn)
						state_ff <= ST_IDLE;
					else if (sclRise && bitCnt_ff == 4'h9) begin
						if (sda) begin
							state_ff    <= ST_WAITNACK;
							sdaDrive_ff <= 1'b0;
							anaOn_ff    <= 1'b0;
						end else
							bitCnt_ff <= 4'hA;
					end else if (sclFall && bitCnt_ff == 4'hA) begin
						// bit must stand before the master raises the clock again
						byteSel_ff  <= ~byteSel_ff;
						bitCnt_ff   <= 4'h1;
						sdaDrive_ff <= byteSel_ff ? 1'b0 : ~(extClk ? extWord[15] : word[7]);
						state_ff    <= extClk ? ST_TRACK : ST_SEND;
						if (!byteSel_ff)
							shift_ff <= {extWord[14:0], 1'b1};
						else if (extClk) begin
							shift_ff   <= 16'hFFFF;
							edgeCnt_ff <= 3'h0;
							track_ff   <= 1'b1;
							if (scanMode == SCAN_UP || scanMode == SCAN_UPPER)
								curCh_ff <= (curCh_ff == lastCh) ? firstCh
								           : curCh_ff + 4'h1;
						end else
							rdPtr_ff <= (rdPtr_ff + 4'h1 == count_ff) ? 4'h0
							           : rdPtr_ff + 4'h1;
					end
				end
				ST_WAITNACK: begin
					sdaDrive_ff <= 1'b0;
					if (endTxn)
						state_ff <= ST_IDLE;
				end
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	// pins and analog control outputs
	always_ff @(posedge clk) begin
		if (reset) begin
			sclOe_n    <= 1'b1;
			sdaOe_n    <= 1'b1;
			adcChannel <= 4'h0;
			adcTrack   <= 1'b0;
			adcStart   <= 1'b0;
			analogOn   <= 1'b0;
		end else begin
			sclOe_n    <= ~sclHold_ff;
			sdaOe_n    <= ~sdaDrive_ff;
			adcChannel <= curCh_ff;
			adcTrack   <= track_ff;
			adcStart   <= start_ff;
			analogOn   <= anaOn_ff;
		end
	end

	// AXI4-Lite write path: address and data taken in either order
	logic        awHave_ff, wHave_ff;
	logic [7:0]  awAddr_ff;
	logic [31:0] wData_ff;
	logic [3:0]  wStrb_ff;
	always_ff @(posedge clk) begin
		if (reset) begin
			awHave_ff     <= 1'b0;
			wHave_ff      <= 1'b0;
			awAddr_ff     <= 8'h0;
			wData_ff      <= 32'h0;
			wStrb_ff      <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			cfg_ff        <= CFG_RESET;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHave_ff     <= 1'b1;
				awAddr_ff     <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHave_ff     <= 1'b1;
				wData_ff     <= s_axi_wdata;
				wStrb_ff     <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (awHave_ff && wHave_ff && !s_axi_bvalid) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (awAddr_ff[7:2] == CFG_OFFSET[7:2]) ? RESP_OKAY : RESP_SLVERR;
				// config change takes effect only while idle to keep a scan coherent
				if (awAddr_ff[7:2] == CFG_OFFSET[7:2] && wStrb_ff[0] && state_ff == ST_IDLE)
					cfg_ff <= wData_ff[7:0];
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				awHave_ff     <= 1'b0;
				wHave_ff      <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// AXI4-Lite read path
	always_ff @(posedge clk) begin
		if (reset) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= RESP_OKAY;
			case (s_axi_araddr[7:2])
				CFG_OFFSET[7:2]:    s_axi_rdata <= {24'h0, cfg_ff};
				STATUS_OFFSET[7:2]: s_axi_rdata <= {16'h0, 4'(state_ff), count_ff, curCh_ff,
				                                    rdPtr_ff};
				default: begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule : asq_scan_readout

// ---- hdl/asq_pkg.sv ----
// shared constants and types for the scan sequencer and readout block
package asq_pkg;
	// AXI4-Lite register byte offsets
	localparam logic [7:0] CFG_OFFSET     = 8'h00;
	localparam logic [7:0] STATUS_OFFSET  = 8'h04;
	localparam logic [7:0] ADC_DATA_OFFSET= 8'h08;
	localparam logic [7:0] CONV_OFFSET    = 8'h0C;
	// configuration field positions
	localparam int CFG_CLK_POS   = 0;
	localparam int CFG_REF_PIN_FUNCTION_BIT_POS  = 1;
	localparam int CFG_SCAN_LSB  = 2;
	localparam int CFG_CS_LSB    = 4;
	// power-on configuration: single conversion (scan 11), ch0, internal clock, pin analog
	localparam logic [7:0] CFG_RESET     = 8'h0C;
	// variant
	localparam int NUM_CH        = 12;
	localparam int MEM_DEPTH     = 12;
	localparam int RES_BITS      = 12;
	localparam logic [3:0] UPPER_START = 4'h6;
	localparam logic [3:0] UPPER_START_SMALL = 4'h2;
	localparam logic [3:0] CH_MAX    = 4'hB;
	localparam logic [3:0] CH_MAX_REF= 4'hA;
	localparam logic [3:0] REPEAT_CNT= 4'h8;
	// timing
	localparam int CLK_MHZ       = 100;
	localparam int STRETCH_NS    = 8300;
	localparam int STRETCH_CYC   = (STRETCH_NS * CLK_MHZ) / 1000;
	localparam int CONV_NS       = 6000;
	localparam int CONV_CYC      = (CONV_NS * CLK_MHZ + 999) / 1000;
	localparam int TRACK_EDGES   = 2;
	localparam int LEAD_HIGH     = 4;
	localparam logic [1:0] SCAN_UP    = 2'b00;
	localparam logic [1:0] SCAN_REPEAT= 2'b01;
	localparam logic [1:0] SCAN_UPPER = 2'b10;
	localparam logic [1:0] SCAN_SINGLE= 2'b11;
	localparam logic [1:0] RESP_OKAY  = 2'b00;
	localparam logic [1:0] RESP_SLVERR= 2'b10;
	typedef enum {ST_IDLE, ST_ADDR, ST_TRACK, ST_CONV, ST_SEND, ST_ACK, ST_WAITNACK} asq_state_t;
endpackage : asq_pkg

// ---- verif/asq_scan_readout_assertions.sv ----
// concurrent checks watching the scan sequencer top ports
`timescale 1ns/1ns
module asq_checker
	import asq_pkg::*;
(
	// system
	input wire logic        clk,
	input wire logic        reset,
	// register bus
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	// link and analog
	input wire logic        busStop,
	input wire logic        sclOe_n,
	input wire logic        sdaOe_n,
	input wire logic        adcStart,
	input wire logic        analogOn
);
	// worst stretch: every channel at the per-channel ceiling
	localparam int STRETCH_MAX = NUM_CH * STRETCH_CYC;
	logic [13:0] stretchCnt_ff;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	always_ff @(posedge clk) begin
		if (reset || sclOe_n)
			stretchCnt_ff <= 14'h0000;
		else
			stretchCnt_ff <= stretchCnt_ff + 14'h0001;
	end
	a_start_single: assert property (adcStart |=> !adcStart)
		else $error("start held over one cycle");
	a_start_powered: assert property (adcStart |-> analogOn)
		else $error("conversion started while analog off");
	a_reset_idle: assert property ($fell(reset) |-> sclOe_n && sdaOe_n && !analogOn)
		else $error("lines not released after reset");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped before ready");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed while waiting");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer missing next cycle");
	a_stretch_bound: assert property (stretchCnt_ff <= STRETCH_MAX)
		else $error("clock held low too long");
	a_stop_idle: assert property (busStop |-> ##[1:8] !analogOn)
		else $error("analog still powered after stop");
endmodule : asq_checker
bind asq_scan_readout asq_checker asq_checker_inst (
	.clk(clk), .reset(reset), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .busStop(busStop),
	.sclOe_n(sclOe_n), .sdaOe_n(sdaOe_n), .adcStart(adcStart), .analogOn(analogOn));

// ---- verif/asq_i2c_master.sv ----
// two-wire bus master model reading conversion results
`timescale 1ns/1ns
module asq_i2c_master (
	// device pull-downs, low holds the wire low
	input wire logic sclOe_n,
	input wire logic sdaOe_n,
	// wire levels and front-end flags
	output logic     sclIn,
	output logic     sdaIn,
	output logic     addrMatch,
	output logic     busStop,
	output logic     busRestart
);
	logic sclM;
	logic sdaM;
	// pull-ups: a released wire reads high
	assign sclIn = sclM & sclOe_n;
	assign sdaIn = sdaM & sdaOe_n;
	initial begin
		sclM = 1'h1;
		sdaM = 1'h1;
		{addrMatch, busStop, busRestart} = 3'h0;
	end
	// every read is a fresh addressed transaction at a 125 ns bit time
	task automatic rd(input int n, output logic [15:0] w [13]);
		sclM = 1'h0;
		addrMatch = 1'h1;
		#62 sclM = 1'h1;
		#63 sclM = 1'h0;
		#62 sclM = 1'h1;
		// bounded wait so a stuck stretch cannot hang the run
		for (int t = 0; t < 20000 && !sclIn; t++) #10;
		addrMatch = 1'h0;
		for (int i = 0; i < 2 * n; i++) begin
			for (int b = 0; b < 8; b++) begin
				w[i / 2] = {w[i / 2][14:0], sdaIn};
				#62 sclM = 1'h0;
				if (b == 7) sdaM = (i == 2 * n - 1);
				#63 sclM = 1'h1;
			end
			#62 sclM = 1'h0;
			sdaM = 1'h1;
			if (i < 2 * n - 1) #63 sclM = 1'h1;
		end
		#63 sclM = 1'h1;
		busStop = 1'h1;
		#125 busStop = 1'h0;
	endtask : rd
endmodule : asq_i2c_master

// ---- verif/asq_scan_readout_tb.sv ----
// self-checking bench for the scan sequencer and readout
`timescale 1ns/1ns
module asq_scan_readout_tb;
	import asq_pkg::*;
	logic        clk, reset, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0]  awaddr, araddr, convCnt;
	logic [31:0] wdata, rdat;
	logic [1:0]  rsp;
	wire         awready, wready, bvalid, arready, rvalid, sclOe_n, sdaOe_n, adcStart;
	wire         analogOn, sclIn, sdaIn, addrMatch, busStop, busRestart;
	wire [1:0]   bresp, rresp;
	wire [31:0]  rdata;
	wire [3:0]   adcChannel;
	wire [11:0]  adcResult;
	int          n_fail, n_tests, cycles;
	asq_scan_readout asq_scan_readout_inst (
		.clk(clk), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.sclIn(sclIn), .sdaIn(sdaIn), .addrMatch(addrMatch), .busStop(busStop),
		.busRestart(busRestart), .sclOe_n(sclOe_n), .sdaOe_n(sdaOe_n), .adcChannel(adcChannel),
		.adcTrack(), .adcStart(adcStart), .analogOn(analogOn), .adcResult(adcResult));
	asq_i2c_master asq_i2c_master_inst (
		.sclOe_n(sclOe_n), .sdaOe_n(sdaOe_n), .sclIn(sclIn), .sdaIn(sdaIn),
		.addrMatch(addrMatch), .busStop(busStop), .busRestart(busRestart));
	// analog stand-in: channel in the top nibble, so order is visible in each word
	assign adcResult = {adcChannel, convCnt};
	always_ff @(posedge clk) begin
		if (reset) convCnt <= 8'h00;
		else if (adcStart) convCnt <= convCnt + 8'h01;
	end
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 100000) begin
			n_fail++;
			end_sim();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic axiWr(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'h0;
			if (wvalid && wready) wvalid <= 1'h0;
		end while (!(bvalid && bready));
		bready <= 1'h0;
		rsp = bresp;
	endtask : axiWr
	task automatic axiRd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'h0;
		end while (!(rvalid && rready));
		rready <= 1'h0;
		rsp = rresp;
		rdat = rdata;
	endtask : axiRd
	task automatic tRegs();
		axiRd(CFG_OFFSET);
		chk(rdat, 32'h0000000C);
		chk(rsp, RESP_OKAY);
		axiRd(ADC_DATA_OFFSET);
		chk(rsp, RESP_SLVERR);
		axiWr(CONV_OFFSET, 32'h00000001);
		chk(rsp, RESP_SLVERR);
		$display("register defaults done");
	endtask : tRegs
	// one word more than stored, so the last must repeat the first
	task automatic runScan(input logic [7:0] cfg, input logic [3:0] ch0, input int n, input int step);
		logic [15:0] w [13];
		logic [7:0]  base;
		axiWr(CFG_OFFSET, {24'h000000, cfg});
		base = convCnt;
		asq_i2c_master_inst.rd(n + 1, w);
		for (int i = 0; i <= n; i++)
			chk(w[i], {4'hF, 4'(ch0 + step * (i % n)), 8'(base + i % n + 1)});
		chk(analogOn, 1'h0);
		chk(sdaOe_n, 1'h1);
		$display("scan with config %h done", cfg);
	endtask : runScan
	task automatic runExt();
		logic [15:0] w [13];
		logic [7:0]  base;
		axiWr(CFG_OFFSET, 32'h0000000D);
		base = convCnt;
		asq_i2c_master_inst.rd(2, w);
		chk(w[0][15:8], 8'hF0);
		chk(w[1][15:8], 8'hF0);
		chk(convCnt != base, 1'h1);
		chk(analogOn, 1'h0);
		$display("external clock read done");
	endtask : runExt
	task automatic end_sim();
		$display("comparisons %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_sim
	initial begin
		{reset, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
		{awaddr, araddr, wdata} = 48'h0;
		repeat (16) @(posedge clk);
		reset <= 1'h0;
		@(posedge clk);
		tRegs();
		runScan(8'h30, 4'h0, 4, 1);
		runScan(8'hF0, 4'h0, 12, 1);
		runScan(8'hF2, 4'h0, 11, 1);
		runScan(8'h54, 4'h5, 8, 0);
		runScan(8'h98, 4'h6, 4, 1);
		runScan(8'h28, 4'h6, 1, 1);
		runScan(8'h7C, 4'h7, 1, 0);
		runExt();
		end_sim();
	end
endmodule : asq_scan_readout_tb
